// File: core/cdr_pkg.sv
package cdr_pkg;

    localparam int CDR_DW = 16;
    localparam int CDR_AW = 8;

    // Register word offsets on the bus
    localparam logic [7:0] CDR_OFS_PC = 8'h00;
    localparam logic [7:0] CDR_OFS_ACC = 8'h04;
    localparam logic [7:0] CDR_OFS_TMP = 8'h08;
    localparam logic [7:0] CDR_OFS_INDEX = 8'h0c;
    localparam logic [7:0] CDR_OFS_EXTRA = 8'h10;
    localparam logic [7:0] CDR_OFS_STACK = 8'h14;
    localparam logic [7:0] CDR_OFS_STATUS = 8'h18;
    localparam logic [7:0] CDR_OFS_BANKADDR = 8'h1c;
    localparam logic [7:0] CDR_OFS_STATE = 8'h20;

    // Reset values
    localparam logic [15:0] CDR_PC_RST = 16'h0000;
    localparam logic [15:0] CDR_WORD_RST = 16'h0000;
    localparam logic [15:0] CDR_PSW_RST = 16'h0030;

    // Banked register area: eight bytes per bank
    localparam logic [15:0] CDR_BANK_BASE = 16'h0100;
    localparam int CDR_BANK_SHIFT = 3;
    localparam int CDR_BANK_BITS = 4;

    // Memory map boundaries
    localparam logic [15:0] CDR_IO_TOP = 16'h007f;
    localparam logic [15:0] CDR_DATA_TOP = 16'h027f;
    localparam logic [15:0] CDR_VECT_BASE = 16'hffc0;

    typedef enum logic [2:0] {
        CDR_SEL_PC = 3'h0,
        CDR_SEL_ACC = 3'h1,
        CDR_SEL_TMP = 3'h2,
        CDR_SEL_INDEX = 3'h3,
        CDR_SEL_EXTRA = 3'h4,
        CDR_SEL_STACK = 3'h5,
        CDR_SEL_STATUS = 3'h6
    } cdr_sel_t;

    typedef enum logic [2:0] {
        CDR_ALU_NONE = 3'h0,
        CDR_ALU_ADD = 3'h1,
        CDR_ALU_SUB = 3'h2,
        CDR_ALU_SHL = 3'h3,
        CDR_ALU_SHR = 3'h4
    } cdr_alu_op_t;

    typedef enum logic [1:0] {
        CDR_MEM_IO = 2'h0,
        CDR_MEM_DATA = 2'h1,
        CDR_MEM_PROG = 2'h2,
        CDR_MEM_VECT = 2'h3
    } cdr_mem_t;

    typedef struct packed {
        logic valid;
        cdr_sel_t sel;
        logic [15:0] data;
    } cdr_wr_t;

    typedef struct packed {
        cdr_alu_op_t op;
        logic wide;
    } cdr_alu_t;

    typedef struct packed {
        logic halfCarry;
        logic intEnable;
        logic [1:0] interruptPriorityMask;
        logic negative;
        logic zero;
        logic overflow;
        logic carry;
    } cdr_flags_t;

    typedef struct packed {
        logic [7:0] bankSelectPointer;
        cdr_flags_t conditionFlagsByte;
    } cdr_psw_t;

    // Mask and request codes 00 and 01 both mean level 1
    function automatic logic [1:0] cdr_level(input logic [1:0] code);
        cdr_level = (code == 2'h0) ? 2'h1 : code;
    endfunction

endpackage

// File: core/cdr_regs.sv
`timescale 1ns/100ps
// Notes on behaviour
// RULE1: Sixteen-bit program counter addresses fetch.
// RULE2: Accumulator and temporary are sixteen-bit operands.
// RULE3: Sixteen-bit index, extra and stack pointers.
// RULE4: Status word: bank pointer high, flags low.
// RULE5: Half carry tracks bit three carry.
// RULE6: Interrupt enable gates interrupts, reset clears.
// RULE7: Accept only requests below priority mask.
// RULE8: Negative flag copies result top bit.
// RULE9: Zero flag set on zero result.
// RULE10: Overflow flag marks two's complement overflow.
// RULE11: Carry from bit seven, or shift-out.
// RULE12: Eight-byte banks, sixteen, chosen by pointer.
// RULE13: Map: I/O low, data, program, vectors top.
// RULE14: Bank base from pointer, fixed conversion.
module cdr_regs
    import cdr_pkg::*;
#(
    parameter logic [15:0] DATA_TOP = CDR_DATA_TOP,
    parameter logic [15:0] VECT_BASE = CDR_VECT_BASE
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [CDR_AW-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire cdr_wr_t cpuWr,
    input wire logic pcInc,
    input wire cdr_alu_t aluCmd,
    input wire logic irqReq,
    input wire logic [1:0] irqLevel,
    input wire logic [2:0] gprSel,
    input wire logic [15:0] memAddr,
    output logic [CDR_DW-1:0] pcOut,
    output logic [CDR_DW-1:0] accOut,
    output logic [CDR_DW-1:0] tmpOut,
    output logic [CDR_DW-1:0] indexOut,
    output logic [CDR_DW-1:0] extraOut,
    output logic [CDR_DW-1:0] stackOut,
    output cdr_psw_t pswOut,
    output logic irqAccept,
    output logic [15:0] gprAddr,
    output cdr_mem_t memRegion
);

    ////////////////////////////////////////////////////////////////////////
    logic [CDR_DW-1:0] pc_reg, pc_next, acc_reg, acc_next, tmp_reg, tmp_next;
    logic [CDR_DW-1:0] index_reg, index_next, extra_reg, extra_next;
    logic [CDR_DW-1:0] stack_reg, stack_next;
    cdr_psw_t psw_reg, psw_next;
    logic irqAccept_reg, irqAccept_next;
    logic [15:0] gprAddr_reg, gprAddr_next;
    cdr_mem_t memRegion_reg, memRegion_next;
    logic [31:0] prdata_reg, prdata_next;
    logic pready_reg, pready_next, pslverr_reg, pslverr_next;

    logic apbSetup, apbWrite, addrOk, addrRo;
    logic [31:0] rdMux;
    logic [16:0] sum17;
    logic [8:0] sum9;
    logic [15:0] aluRes;
    logic isSub, resMsb, opMsbA, opMsbB;

    assign apbSetup = psel && !penable;
    assign apbWrite = psel && penable && pready_reg && pwrite;

    always_comb begin
        addrOk = 1'b1;
        addrRo = 1'b0;
        rdMux = 32'h0000_0000;
        case (paddr)
            CDR_OFS_PC: rdMux[15:0] = pc_reg;
            CDR_OFS_ACC: rdMux[15:0] = acc_reg;
            CDR_OFS_TMP: rdMux[15:0] = tmp_reg;
            CDR_OFS_INDEX: rdMux[15:0] = index_reg;
            CDR_OFS_EXTRA: rdMux[15:0] = extra_reg;
            CDR_OFS_STACK: rdMux[15:0] = stack_reg;
            CDR_OFS_STATUS: rdMux[15:0] = psw_reg;
            CDR_OFS_BANKADDR: begin
                rdMux[15:0] = gprAddr_reg;
                addrRo = 1'b1;
            end
            CDR_OFS_STATE: begin
                rdMux[2:0] = {memRegion_reg, irqAccept_reg};
                addrRo = 1'b1;
            end
            default: addrOk = 1'b0;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // Arithmetic on accumulator (first operand) and temporary (second)
    always_comb begin
        isSub = (aluCmd.op == CDR_ALU_SUB);
        sum17 = isSub ? ({1'b0, acc_reg} - {1'b0, tmp_reg}) : ({1'b0, acc_reg} + {1'b0, tmp_reg}); // RULE2
        sum9 = isSub ? ({1'b0, acc_reg[7:0]} - {1'b0, tmp_reg[7:0]})
                     : ({1'b0, acc_reg[7:0]} + {1'b0, tmp_reg[7:0]});
        // Byte operations leave the upper accumulator byte untouched
        aluRes = aluCmd.wide ? sum17[15:0] : {acc_reg[15:8], sum9[7:0]}; // RULE2
        case (aluCmd.op)
            CDR_ALU_SHL: aluRes = aluCmd.wide ? {acc_reg[14:0], 1'b0} : {acc_reg[15:8], acc_reg[6:0], 1'b0};
            CDR_ALU_SHR: aluRes = aluCmd.wide ? {1'b0, acc_reg[15:1]} : {acc_reg[15:8], 1'b0, acc_reg[7:1]};
            default: ;
        endcase
        resMsb = aluCmd.wide ? aluRes[15] : aluRes[7];
        opMsbA = aluCmd.wide ? acc_reg[15] : acc_reg[7];
        opMsbB = aluCmd.wide ? tmp_reg[15] : tmp_reg[7];
    end

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        pc_next = pc_reg;
        acc_next = acc_reg;
        tmp_next = tmp_reg;
        index_next = index_reg;
        extra_next = extra_reg;
        stack_next = stack_reg;
        psw_next = psw_reg;
        if (pcInc) begin
            pc_next = pc_reg + 16'h0001; // RULE1
        end
        // PC increment first, then software, then sequencer writes, then the ALU: later wins
        if (apbWrite && addrOk && !addrRo) begin
            case (paddr)
                CDR_OFS_PC: pc_next = pwdata[15:0];
                CDR_OFS_ACC: acc_next = pwdata[15:0];
                CDR_OFS_TMP: tmp_next = pwdata[15:0];
                CDR_OFS_INDEX: index_next = pwdata[15:0]; // RULE3
                CDR_OFS_EXTRA: extra_next = pwdata[15:0];
                CDR_OFS_STACK: stack_next = pwdata[15:0];
                CDR_OFS_STATUS: psw_next = pwdata[15:0]; // RULE4
                default: ;
            endcase
        end
        if (cpuWr.valid) begin
            case (cpuWr.sel)
                CDR_SEL_PC: pc_next = cpuWr.data; // RULE1
                CDR_SEL_ACC: acc_next = cpuWr.data;
                CDR_SEL_TMP: tmp_next = cpuWr.data;
                CDR_SEL_INDEX: index_next = cpuWr.data; // RULE3
                CDR_SEL_EXTRA: extra_next = cpuWr.data;
                CDR_SEL_STACK: stack_next = cpuWr.data;
                CDR_SEL_STATUS: psw_next = cpuWr.data; // RULE4
                default: ;
            endcase
        end
        // Flags set by hardware win over a same-cycle software write
        if (aluCmd.op != CDR_ALU_NONE) begin
            acc_next = aluRes;
            psw_next.conditionFlagsByte.negative = resMsb; // RULE8
            psw_next.conditionFlagsByte.zero = aluCmd.wide ? (aluRes == 16'h0000) : (aluRes[7:0] == 8'h00); // RULE9
            case (aluCmd.op)
                CDR_ALU_SHL: begin
                    psw_next.conditionFlagsByte.carry = opMsbA; // RULE11
                    psw_next.conditionFlagsByte.overflow = 1'b0;
                end
                CDR_ALU_SHR: begin
                    psw_next.conditionFlagsByte.carry = acc_reg[0]; // RULE11
                    psw_next.conditionFlagsByte.overflow = 1'b0;
                end
                default: begin
                    psw_next.conditionFlagsByte.carry = aluCmd.wide ? sum17[16] : sum9[8]; // RULE11
                    psw_next.conditionFlagsByte.halfCarry = acc_reg[4] ^ tmp_reg[4] ^ aluRes[4]; // RULE5
                    psw_next.conditionFlagsByte.overflow = isSub ? ((opMsbA != opMsbB) && (resMsb != opMsbA))
                                                                 : ((opMsbA == opMsbB) && (resMsb != opMsbA)); // RULE10
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        irqAccept_next = irqReq && psw_reg.conditionFlagsByte.intEnable // RULE6
            && (cdr_level(irqLevel) < cdr_level(psw_reg.conditionFlagsByte.interruptPriorityMask)); // RULE7
        // Fixed conversion: bank n starts eight bytes per bank above the base
        gprAddr_next = CDR_BANK_BASE
            + {9'h000, psw_reg.bankSelectPointer[CDR_BANK_BITS-1:0], 3'h0} + {13'h0000, gprSel}; // RULE12 RULE14
        if (memAddr <= CDR_IO_TOP) begin
            memRegion_next = CDR_MEM_IO; // RULE13
        end else if (memAddr <= DATA_TOP) begin
            memRegion_next = CDR_MEM_DATA;
        end else if (memAddr >= VECT_BASE) begin
            memRegion_next = CDR_MEM_VECT;
        end else begin
            memRegion_next = CDR_MEM_PROG;
        end
        // Zero-wait answer: pready is raised for the access cycle only
        pready_next = apbSetup;
        prdata_next = apbSetup ? rdMux : prdata_reg;
        pslverr_next = apbSetup ? (!addrOk || (pwrite && addrRo)) : pslverr_reg;
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            pc_reg <= CDR_PC_RST;
            acc_reg <= CDR_WORD_RST;
            tmp_reg <= CDR_WORD_RST;
            index_reg <= CDR_WORD_RST;
            extra_reg <= CDR_WORD_RST;
            stack_reg <= CDR_WORD_RST;
            psw_reg <= CDR_PSW_RST; // RULE6
            irqAccept_reg <= 1'b0;
            gprAddr_reg <= CDR_BANK_BASE;
            memRegion_reg <= CDR_MEM_IO;
            prdata_reg <= 32'h0000_0000;
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
        end else begin
            pc_reg <= pc_next;
            acc_reg <= acc_next;
            tmp_reg <= tmp_next;
            index_reg <= index_next;
            extra_reg <= extra_next;
            stack_reg <= stack_next;
            psw_reg <= psw_next;
            irqAccept_reg <= irqAccept_next;
            gprAddr_reg <= gprAddr_next;
            memRegion_reg <= memRegion_next;
            prdata_reg <= prdata_next;
            pready_reg <= pready_next;
            pslverr_reg <= pslverr_next;
        end
    end

    assign pcOut = pc_reg;
    assign accOut = acc_reg;
    assign tmpOut = tmp_reg;
    assign indexOut = index_reg;
    assign extraOut = extra_reg;
    assign stackOut = stack_reg;
    assign pswOut = psw_reg;
    assign irqAccept = irqAccept_reg;
    assign gprAddr = gprAddr_reg;
    assign memRegion = memRegion_reg;
    assign prdata = prdata_reg;
    assign pready = pready_reg;
    assign pslverr = pslverr_reg;

    ////////////////////////////////////////////////////////////////////////
    logic aluByteAdd;
    assign aluByteAdd = (aluCmd.op == CDR_ALU_ADD) && !aluCmd.wide;

    property p_ie_reset;
        @(posedge sys_clk) rst |=> !pswOut.conditionFlagsByte.intEnable && !irqAccept;
    endproperty
    a_ie_reset: assert property (p_ie_reset) else $error("enable flag not cleared by reset"); // RULE6

    property p_ie_blocks;
        @(posedge sys_clk) disable iff (rst) !pswOut.conditionFlagsByte.intEnable |=> !irqAccept;
    endproperty
    a_ie_blocks: assert property (p_ie_blocks) else $error("interrupt accepted while disabled"); // RULE6

    property p_level;
        @(posedge sys_clk) disable iff (rst)
            irqReq && pswOut.conditionFlagsByte.intEnable |=> irqAccept ==
            (cdr_level($past(irqLevel)) < cdr_level($past(pswOut.conditionFlagsByte.interruptPriorityMask)));
    endproperty
    a_level: assert property (p_level) else $error("priority compare wrong"); // RULE7

    property p_neg_zero;
        @(posedge sys_clk) disable iff (rst)
            aluCmd.op != CDR_ALU_NONE && !aluCmd.wide |=>
            pswOut.conditionFlagsByte.negative == accOut[7] && pswOut.conditionFlagsByte.zero == (accOut[7:0] == 8'h00);
    endproperty
    a_neg_zero: assert property (p_neg_zero) else $error("negative or zero flag wrong"); // RULE8 RULE9

    property p_half;
        @(posedge sys_clk) disable iff (rst)
            aluByteAdd |=> pswOut.conditionFlagsByte.halfCarry ==
            (({1'b0, $past(accOut[3:0])} + {1'b0, $past(tmpOut[3:0])}) > 5'h0f);
    endproperty
    a_half: assert property (p_half) else $error("half carry wrong"); // RULE5

    property p_carry_ovf;
        @(posedge sys_clk) disable iff (rst)
            aluByteAdd |=> pswOut.conditionFlagsByte.carry ==
            (({1'b0, $past(accOut[7:0])} + {1'b0, $past(tmpOut[7:0])}) > 9'h0ff)
            && pswOut.conditionFlagsByte.overflow ==
            (($past(accOut[7]) == $past(tmpOut[7])) && (accOut[7] != $past(accOut[7])));
    endproperty
    a_carry_ovf: assert property (p_carry_ovf) else $error("carry or overflow wrong"); // RULE10 RULE11

    property p_shift;
        @(posedge sys_clk) disable iff (rst)
            aluCmd.op == CDR_ALU_SHR |=> pswOut.conditionFlagsByte.carry == $past(accOut[0]);
    endproperty
    a_shift: assert property (p_shift) else $error("shift-out not in carry"); // RULE11

    property p_bank;
        @(posedge sys_clk) disable iff (rst)
            1'b1 |=> gprAddr == CDR_BANK_BASE + {5'h00, $past(pswOut.bankSelectPointer[3:0]), $past(gprSel)};
    endproperty
    a_bank: assert property (p_bank) else $error("bank address wrong"); // RULE12 RULE14

    property p_region;
        @(posedge sys_clk) disable iff (rst)
            memAddr <= CDR_IO_TOP ##1 memAddr >= VECT_BASE |-> memRegion == CDR_MEM_IO ##1 memRegion == CDR_MEM_VECT;
    endproperty
    a_region: assert property (p_region) else $error("memory region wrong"); // RULE13

    property p_pc_inc;
        @(posedge sys_clk) disable iff (rst)
            pcInc && !cpuWr.valid && !apbWrite |=> pcOut == $past(pcOut) + 16'h0001;
    endproperty
    a_pc_inc: assert property (p_pc_inc) else $error("counter did not advance"); // RULE1

endmodule

// File: sim/cdr_seq_model.sv
`timescale 1ns/100ps
////////////////////////////////////////////////////////////////
// Sequencer stand-in: one-cycle command pulses, one idle cycle after each
module cdr_seq_model
    import cdr_pkg::*;
(
    input wire logic sys_clk,
    output cdr_wr_t cpuWr,
    output logic pcInc,
    output cdr_alu_t aluCmd
);
    initial begin
        cpuWr = '0;
        pcInc = 1'b0;
        aluCmd = '0;
    end

    ////////////////////////////////////////////////////////////////
    task automatic put(input cdr_sel_t sel, input logic [15:0] data);
        cpuWr <= '{valid: 1'b1, sel: sel, data: data};
        @(posedge sys_clk);
        // Idle bus shows the inverse so a stale value cannot pass for a write
        cpuWr <= '{valid: 1'b0, sel: sel, data: ~data};
        @(posedge sys_clk);
    endtask

    task automatic step(input logic inc, input cdr_alu_op_t op, input logic wide);
        pcInc <= inc;
        aluCmd <= '{op: op, wide: wide};
        @(posedge sys_clk);
        pcInc <= 1'b0;
        aluCmd <= '{op: CDR_ALU_NONE, wide: ~wide};
        @(posedge sys_clk);
    endtask
endmodule

// File: sim/cpu_dedicated_registers_flags_bench.sv
`timescale 1ns/100ps
module cpu_dedicated_registers_flags_bench
    import cdr_pkg::*;
;
    logic sys_clk;
    logic rst;
    logic psel, penable, pwrite, pready, pslverr;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata;
    cdr_wr_t cpuWr;
    logic pcInc, irqReq, irqAccept;
    cdr_alu_t aluCmd;
    logic [1:0] irqLevel;
    logic [2:0] gprSel;
    logic [15:0] memAddr, gprAddr;
    logic [15:0] pcOut, accOut, tmpOut, indexOut, extraOut, stackOut;
    cdr_psw_t pswOut;
    cdr_mem_t memRegion;
    // All seven registers side by side, in the order of the sequencer's select codes
    logic [111:0] regWords;
    assign regWords = {pswOut, stackOut, extraOut, indexOut, tmpOut, accOut, pcOut};
    logic [33:0] expQ[$];
    // An I/O address straight followed by a vector address exercises the region assertion
    logic [15:0] mapAt [8] = '{16'h0000, 16'hffc0, 16'h007f, 16'h0080, 16'h027f, 16'h0280, 16'hffbf, 16'hffff};
    logic [7:0] ta [4] = '{8'h7f, 8'h00, 8'h81, 8'h01};
    int fails = 0;
    int numChecks = 0;
    int cycles = 0;

    cdr_regs cdr_regs_inst (.sys_clk(sys_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .cpuWr(cpuWr),
        .pcInc(pcInc), .aluCmd(aluCmd), .irqReq(irqReq), .irqLevel(irqLevel), .gprSel(gprSel),
        .memAddr(memAddr), .pcOut(pcOut), .accOut(accOut), .tmpOut(tmpOut), .indexOut(indexOut),
        .extraOut(extraOut), .stackOut(stackOut), .pswOut(pswOut), .irqAccept(irqAccept),
        .gprAddr(gprAddr), .memRegion(memRegion));
    cdr_seq_model cdr_seq_model_inst (.sys_clk(sys_clk), .cpuWr(cpuWr), .pcInc(pcInc), .aluCmd(aluCmd));

    initial begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end

    ////////////////////////////////////////////////////////////////
    task automatic printVerdict();
        $display("checks %0d mismatches %0d", numChecks, fails);
        if (fails == 0 && numChecks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // Note layout: {is read, error, read data}
    task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] wdata, input logic [33:0] e);
        expQ.push_back(e);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= addr;
        pwdata <= wdata;
        @(posedge sys_clk);
        penable <= 1'b1;
        // Hold the access until pready is seen high at a rising edge; only the timeout ends a hang
        do begin
            @(posedge sys_clk);
        end while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
        pwdata <= ~wdata;
        @(posedge sys_clk);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] d);
        apb(1'b0, a, $urandom, {2'b10, d});
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic err);
        apb(1'b1, a, d, {1'b0, err, 32'h0});
    endtask

    function automatic logic [7:0] alu8(input cdr_alu_op_t op, input logic [7:0] a, input logic [7:0] b,
                                        inout logic [15:0] ps);
        logic [8:0] s;
        logic h;
        logic v;
        h = ps[7];
        v = 1'b0;
        case (op)
            CDR_ALU_ADD: begin
                s = {1'b0, a} + {1'b0, b};
                h = ({1'b0, a[3:0]} + {1'b0, b[3:0]}) > 5'h0f;
                v = (a[7] == b[7]) && (s[7] != a[7]);
            end
            CDR_ALU_SUB: begin
                s = {1'b0, a} - {1'b0, b};
                h = a[3:0] < b[3:0];
                v = (a[7] != b[7]) && (s[7] != a[7]);
            end
            CDR_ALU_SHL: s = {a, 1'b0};
            default: s = {a[0], 1'b0, a[7:1]};
        endcase
        ps[7:0] = {h, ps[6:4], s[7], s[7:0] == 8'h00, v, s[8]};
        return s[7:0];
    endfunction

    ////////////////////////////////////////////////////////////////
    always @(posedge sys_clk) begin
        logic [33:0] e;
        if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1) begin
            e = expQ.pop_front();
            numChecks++;
            if (e[33] ? ({pslverr, prdata} !== e[32:0]) : (pslverr !== e[32])) begin
                fails++;
                $display("unexpected at %0t: got %h %h expected %h", $time, pslverr, prdata, e[32:0]);
            end
        end
    end

    // Whole run needs about 1000 cycles; the ceiling leaves wide margin
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 20000) begin
            fails++;
            printVerdict();
        end
    end

    initial begin
        logic [15:0] a, b, d, psw;
        logic [7:0] r, bp;
        logic [1:0] lm, lr, rg;
        logic ie, acpt;
        cdr_alu_op_t op;
        rst = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        irqReq = 1'b0;
        irqLevel = 2'h0;
        gprSel = 3'h0;
        memAddr = 16'h0000;
        void'($urandom(30));
        repeat (3) @(posedge sys_clk);
        rst <= 1'b0;
        @(posedge sys_clk);
        rd(CDR_OFS_PC, 32'h0);
        rd(CDR_OFS_STATUS, 32'h0030);
        rd(CDR_OFS_BANKADDR, 32'h0100);
        rd(CDR_OFS_STATE, 32'h0);
        for (int s = 0; s < 7; s++) begin
            d = 16'($urandom);
            wr(CDR_OFS_PC + 8'(4 * s), {16'($urandom), d}, 1'b0);
            rd(CDR_OFS_PC + 8'(4 * s), {16'h0, d});
            d = 16'($urandom);
            cdr_seq_model_inst.put(cdr_sel_t'(s), d);
            numChecks++;
            if (regWords[16 * s +: 16] !== d) begin
                fails++;
                $display("unexpected at %0t: got %h expected %h", $time, regWords[16 * s +: 16], d);
            end
            rd(CDR_OFS_PC + 8'(4 * s), {16'h0, d});
        end
        wr(CDR_OFS_BANKADDR, 32'h0000ffff, 1'b1);
        wr(8'h24, 32'h0000ffff, 1'b1);
        apb(1'b0, 8'h24, 32'h0, {2'b11, 32'h0});
        cdr_seq_model_inst.put(CDR_SEL_PC, 16'hffff);
        cdr_seq_model_inst.step(1'b1, CDR_ALU_NONE, 1'b0);
        rd(CDR_OFS_PC, 32'h0);
        psw = 16'h5a00;
        cdr_seq_model_inst.put(CDR_SEL_STATUS, psw);
        for (int i = 0; i < 24; i++) begin
            a = 16'($urandom);
            b = 16'($urandom);
            op = cdr_alu_op_t'(1 + i % 4);
            if (i < 4) begin
                a[7:0] = ta[i];
                b[7:0] = 8'h01;
            end
            cdr_seq_model_inst.put(CDR_SEL_ACC, a);
            cdr_seq_model_inst.put(CDR_SEL_TMP, b);
            cdr_seq_model_inst.step(1'b0, op, 1'b0);
            r = alu8(op, a[7:0], b[7:0], psw);
            rd(CDR_OFS_ACC, {16'h0, a[15:8], r});
            rd(CDR_OFS_STATUS, {16'h0, psw});
        end
        cdr_seq_model_inst.put(CDR_SEL_ACC, 16'hffff);
        cdr_seq_model_inst.put(CDR_SEL_TMP, 16'h0001);
        cdr_seq_model_inst.step(1'b0, CDR_ALU_ADD, 1'b1);
        rd(CDR_OFS_ACC, 32'h0);
        for (int i = 0; i < 64; i++) begin
            bp = 8'($urandom);
            lm = i[1:0];
            lr = i[3:2];
            ie = i[4];
            d = mapAt[i % 8];
            cdr_seq_model_inst.put(CDR_SEL_STATUS, {bp, 1'b0, ie, lm, 4'h0});
            irqReq <= i[5];
            irqLevel <= lr;
            gprSel <= i[2:0];
            memAddr <= d;
            @(posedge sys_clk);
            acpt = ie && i[5] && ((lr == 2'h0 ? 2'h1 : lr) < (lm == 2'h0 ? 2'h1 : lm));
            rg = (d <= CDR_IO_TOP) ? 2'h0 : (d <= CDR_DATA_TOP) ? 2'h1 : (d >= CDR_VECT_BASE) ? 2'h3 : 2'h2;
            rd(CDR_OFS_STATE, {29'h0, rg, acpt});
            rd(CDR_OFS_BANKADDR, {16'h0, 16'h0100 + {9'h0, bp[3:0], i[2:0]}});
        end
        printVerdict();
    end
endmodule
